/* include/srb_pkg.sv */
// Package with the map, field layout and reset values of the special register bank slice.
package srb_pkg;

  localparam int ADDR_W = 12;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [8:0] IDX_DPTR_LO = 9'h082;
  localparam logic [8:0] IDX_DPTR_HI = 9'h083;
  localparam logic [8:0] IDX_CLKDIV = 9'h095;
  localparam logic [8:0] IDX_AUXFN = 9'h0a2;
  localparam logic [8:0] IDX_CMP_ONE = 9'h0ac;
  localparam logic [8:0] IDX_CMP_TWO = 9'h0ad;
  localparam logic [8:0] IDX_BAUD_CTL = 9'h0bd;
  localparam logic [8:0] IDX_BAUD_LO = 9'h0be;
  localparam logic [8:0] IDX_BAUD_HI = 9'h0bf;
  localparam logic [8:0] IDX_ACCUM = 9'h0e0;
  localparam logic [8:0] IDX_FLASH_LO = 9'h0e6;
  localparam logic [8:0] IDX_FLASH_HI = 9'h0e7;
  localparam logic [8:0] IDX_ARITH2 = 9'h0f0;

  // Bit space: index = base + bit address; groups select the owning byte.
  localparam logic [8:0] IDX_BIT_BASE = 9'h100;
  localparam logic [4:0] BIT_GRP_ACCUM = 5'h1c;
  localparam logic [4:0] BIT_GRP_ARITH2 = 5'h1e;

  // Reset values.
  localparam logic [7:0] RST_DPTR_LO = 8'h00;
  localparam logic [7:0] RST_DPTR_HI = 8'h00;
  localparam logic [7:0] RST_CLKDIV = 8'h00;
  localparam logic [7:0] RST_AUXFN = 8'h00;
  localparam logic [7:0] RST_CMP = 8'h00;
  localparam logic [7:0] RST_BAUD_CTL = 8'h00;
  localparam logic [7:0] RST_BAUD_LO = 8'h00;
  localparam logic [7:0] RST_BAUD_HI = 8'h00;
  localparam logic [7:0] RST_ACCUM = 8'h00;
  localparam logic [7:0] RST_FLASH_LO = 8'h00;
  localparam logic [7:0] RST_FLASH_HI = 8'h00;
  localparam logic [7:0] RST_ARITH2 = 8'h00;

  // Storage masks (stored bits) and fixed-one masks per register.
  localparam logic [7:0] AUXFN_STORE = 8'hf9;
  localparam logic [7:0] AUXFN_FIX1 = 8'h00;
  localparam logic [7:0] BAUD_CTL_STORE = 8'h03;
  localparam logic [7:0] BAUD_CTL_FIX1 = 8'h00;

  // Comparator control field positions.
  localparam int CMP_ENABLE_POS = 5;
  localparam int CMP_POS_SEL_POS = 4;
  localparam int CMP_NEG_SEL_POS = 3;
  localparam int CMP_OUT_EN_POS = 2;
  localparam int CMP_OUT_VAL_POS = 1;
  localparam int CMP_FLAG_POS = 0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : srb_pkg

/* rtl/srb_cmp_reg.sv */
// One comparator control register: control fields, live output value and change flag.
`timescale 1ns/1ps
module srb_cmp_reg (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic cmp_level,
  output logic [3:0] ctrl_q,
  output logic [7:0] reg_value
);

  logic [3:0] ctrl_d;
  logic out_val_q;
  logic out_val_d;
  logic flag_q;
  logic flag_d;
  logic change;

  always_comb
  begin
    ctrl_d = ctrl_q;
    out_val_d = out_val_q;
    change = 1'b0;
    if (ctrl_q[3])
    begin
      out_val_d = cmp_level;
      change = (cmp_level != out_val_q);
    end
    flag_d = flag_q;
    if (wr_en)
    begin
      ctrl_d = wr_data[srb_pkg::CMP_ENABLE_POS:srb_pkg::CMP_OUT_EN_POS];
      flag_d = flag_q & wr_data[srb_pkg::CMP_FLAG_POS];
    end
    // A change in the clearing cycle still sets the flag.
    if (change)
    begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= srb_pkg::RST_CMP[5:2];
      out_val_q <= srb_pkg::RST_CMP[1];
      flag_q <= srb_pkg::RST_CMP[0];
    end
    else
    begin
      ctrl_q <= ctrl_d;
      out_val_q <= out_val_d;
      flag_q <= flag_d;
    end
  end

  // Reserved top bits read as zero.
  assign reg_value = {2'h0, ctrl_q, out_val_q, flag_q};

endmodule : srb_cmp_reg

/* rtl/srb_sync3.sv */
// Three-stage pin synchroniser that accepts a new level once stages two and three agree.
`timescale 1ns/1ps
module srb_sync3 (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin_in,
  output logic level_q
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_d;

  always_comb
  begin
    level_d = (s2_q == s3_q) ? s3_q : level_q;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
    end
  end

endmodule : srb_sync3

/* rtl/srb_top.sv */
// AXI4-Lite special register bank slice with bit access to two arithmetic registers.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module srb_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [srb_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [srb_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cmp_one_pin,
  input wire logic cmp_two_pin,
  output logic [7:0] accumulator_register_q,
  output logic [7:0] second_arith_register_q,
  output logic [7:0] data_pointer_low_q,
  output logic [7:0] data_pointer_high_q,
  output logic [7:0] core_clock_divider_q,
  output logic [7:0] auxiliary_function_control_q,
  output logic [7:0] baud_generator_control_q,
  output logic [7:0] baud_rate_low_byte_q,
  output logic [7:0] baud_rate_high_byte_q,
  output logic [7:0] flash_address_low_q,
  output logic [7:0] flash_address_high_q,
  output logic [3:0] comparator_one_ctrl_q,
  output logic [3:0] comparator_two_ctrl_q
);

  logic aw_full_q;
  logic aw_full_d;
  logic w_full_q;
  logic w_full_d;
  logic [8:0] wr_idx_q;
  logic [8:0] wr_idx_d;
  logic wr_hi_q;
  logic wr_hi_d;
  logic [7:0] wr_byte_q;
  logic [7:0] wr_byte_d;
  logic wr_lane_q;
  logic wr_lane_d;
  logic awready_d;
  logic wready_d;
  logic bvalid_d;
  logic [1:0] bresp_d;
  logic arready_d;
  logic rvalid_d;
  logic [31:0] rdata_d;
  logic [1:0] rresp_d;
  logic do_wr;
  logic ar_hs;
  logic wr_hit;
  logic wr_en;
  logic rd_hit;
  logic [7:0] rd_byte;
  logic [8:0] rd_idx;
  logic [7:0] accum_d;
  logic [7:0] arith2_d;
  logic [7:0] dptr_lo_d;
  logic [7:0] dptr_hi_d;
  logic [7:0] clkdiv_d;
  logic [7:0] auxfn_d;
  logic [7:0] baud_ctl_d;
  logic [7:0] baud_lo_d;
  logic [7:0] baud_hi_d;
  logic [7:0] flash_lo_d;
  logic [7:0] flash_hi_d;
  logic cmp_one_lvl;
  logic cmp_two_lvl;
  logic cmp_one_wr;
  logic cmp_two_wr;
  logic [7:0] cmp_one_val;
  logic [7:0] cmp_two_val;

  // True when the index names a defined byte register or a defined bit.
  function automatic logic decode_hit(input logic hi, input logic [8:0] idx);
    logic hit;
    hit = 1'b0;
    if (!hi)
    begin
      if (idx[8])
      begin
        hit = (idx[7:3] == srb_pkg::BIT_GRP_ACCUM) || (idx[7:3] == srb_pkg::BIT_GRP_ARITH2);
      end
      else
      begin
        unique case (idx)
          srb_pkg::IDX_DPTR_LO, srb_pkg::IDX_DPTR_HI, srb_pkg::IDX_CLKDIV,
          srb_pkg::IDX_AUXFN, srb_pkg::IDX_CMP_ONE, srb_pkg::IDX_CMP_TWO,
          srb_pkg::IDX_BAUD_CTL, srb_pkg::IDX_BAUD_LO, srb_pkg::IDX_BAUD_HI,
          srb_pkg::IDX_ACCUM, srb_pkg::IDX_FLASH_LO, srb_pkg::IDX_FLASH_HI,
          srb_pkg::IDX_ARITH2: hit = 1'b1;
          default: hit = 1'b0;
        endcase
      end
    end
    return hit;
  endfunction : decode_hit

  // True when the index is one of the bits of the given group.
  function automatic logic bit_in(input logic [8:0] idx, input logic [4:0] grp);
    return idx[8] && (idx[7:3] == grp);
  endfunction : bit_in

  srb_sync3 u_sync_one (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(cmp_one_pin),
    .level_q(cmp_one_lvl)
  );

  srb_sync3 u_sync_two (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(cmp_two_pin),
    .level_q(cmp_two_lvl)
  );

  srb_cmp_reg u_cmp_one (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(cmp_one_wr),
    .wr_data(wr_byte_q),
    .cmp_level(cmp_one_lvl),
    .ctrl_q(comparator_one_ctrl_q),
    .reg_value(cmp_one_val)
  );

  srb_cmp_reg u_cmp_two (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(cmp_two_wr),
    .wr_data(wr_byte_q),
    .cmp_level(cmp_two_lvl),
    .ctrl_q(comparator_two_ctrl_q),
    .reg_value(cmp_two_val)
  );

  assign rd_idx = s_axi_araddr[10:2];
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  // The write waits for a pending response so one write is in flight at a time.
  assign do_wr = aw_full_q && w_full_q && !s_axi_bvalid;
  assign wr_hit = decode_hit(wr_hi_q, wr_idx_q);
  assign wr_en = do_wr && wr_hit && wr_lane_q;
  assign cmp_one_wr = wr_en && (wr_idx_q == srb_pkg::IDX_CMP_ONE);
  assign cmp_two_wr = wr_en && (wr_idx_q == srb_pkg::IDX_CMP_TWO);

  // Write channels are captured independently and in either order.
  always_comb
  begin
    aw_full_d = aw_full_q;
    w_full_d = w_full_q;
    wr_idx_d = wr_idx_q;
    wr_hi_d = wr_hi_q;
    wr_byte_d = wr_byte_q;
    wr_lane_d = wr_lane_q;
    if (do_wr)
    begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
    end
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_full_d = 1'b1;
      wr_idx_d = s_axi_awaddr[10:2];
      wr_hi_d = s_axi_awaddr[11];
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_full_d = 1'b1;
      wr_byte_d = s_axi_wdata[7:0];
      wr_lane_d = s_axi_wstrb[0];
    end
    awready_d = !aw_full_d;
    wready_d = !w_full_d;
    bvalid_d = do_wr || (s_axi_bvalid && !s_axi_bready);
    bresp_d = s_axi_bresp;
    if (do_wr)
    begin
      bresp_d = wr_hit ? srb_pkg::RESP_OKAY : srb_pkg::RESP_SLVERR;
    end
  end

  // Read mux, evaluated in the address cycle.
  always_comb
  begin
    rd_hit = decode_hit(s_axi_araddr[11], rd_idx);
    rd_byte = 8'h00;
    // The upper half is unmapped, so a bit index there must not leak register data.
    if (rd_hit && bit_in(rd_idx, srb_pkg::BIT_GRP_ACCUM))
    begin
      rd_byte = {7'h00, accumulator_register_q[rd_idx[2:0]]};
    end
    else if (rd_hit && bit_in(rd_idx, srb_pkg::BIT_GRP_ARITH2))
    begin
      rd_byte = {7'h00, second_arith_register_q[rd_idx[2:0]]};
    end
    else if (rd_hit)
    begin
      unique case (rd_idx)
        srb_pkg::IDX_DPTR_LO: rd_byte = data_pointer_low_q;
        srb_pkg::IDX_DPTR_HI: rd_byte = data_pointer_high_q;
        srb_pkg::IDX_CLKDIV: rd_byte = core_clock_divider_q;
        srb_pkg::IDX_AUXFN: rd_byte = auxiliary_function_control_q | srb_pkg::AUXFN_FIX1;
        srb_pkg::IDX_CMP_ONE: rd_byte = cmp_one_val;
        srb_pkg::IDX_CMP_TWO: rd_byte = cmp_two_val;
        srb_pkg::IDX_BAUD_CTL: rd_byte = baud_generator_control_q | srb_pkg::BAUD_CTL_FIX1;
        srb_pkg::IDX_BAUD_LO: rd_byte = baud_rate_low_byte_q;
        srb_pkg::IDX_BAUD_HI: rd_byte = baud_rate_high_byte_q;
        srb_pkg::IDX_ACCUM: rd_byte = accumulator_register_q;
        srb_pkg::IDX_FLASH_LO: rd_byte = flash_address_low_q;
        srb_pkg::IDX_FLASH_HI: rd_byte = flash_address_high_q;
        srb_pkg::IDX_ARITH2: rd_byte = second_arith_register_q;
        default: rd_byte = 8'h00;
      endcase
    end
    rvalid_d = ar_hs || (s_axi_rvalid && !s_axi_rready);
    arready_d = !rvalid_d;
    rdata_d = s_axi_rdata;
    rresp_d = s_axi_rresp;
    if (ar_hs)
    begin
      rdata_d = {24'h000000, rd_byte};
      rresp_d = rd_hit ? srb_pkg::RESP_OKAY : srb_pkg::RESP_SLVERR;
    end
  end

  // Register file next values.
  always_comb
  begin
    accum_d = accumulator_register_q;
    arith2_d = second_arith_register_q;
    dptr_lo_d = data_pointer_low_q;
    dptr_hi_d = data_pointer_high_q;
    clkdiv_d = core_clock_divider_q;
    auxfn_d = auxiliary_function_control_q;
    baud_ctl_d = baud_generator_control_q;
    baud_lo_d = baud_rate_low_byte_q;
    baud_hi_d = baud_rate_high_byte_q;
    flash_lo_d = flash_address_low_q;
    flash_hi_d = flash_address_high_q;
    if (wr_en && bit_in(wr_idx_q, srb_pkg::BIT_GRP_ACCUM))
    begin
      accum_d[wr_idx_q[2:0]] = wr_byte_q[0];
    end
    else if (wr_en && bit_in(wr_idx_q, srb_pkg::BIT_GRP_ARITH2))
    begin
      arith2_d[wr_idx_q[2:0]] = wr_byte_q[0];
    end
    else if (wr_en)
    begin
      unique case (wr_idx_q)
        srb_pkg::IDX_DPTR_LO: dptr_lo_d = wr_byte_q;
        srb_pkg::IDX_DPTR_HI: dptr_hi_d = wr_byte_q;
        srb_pkg::IDX_CLKDIV: clkdiv_d = wr_byte_q;
        // Reserved and fixed-zero bits are not stored, so they read back zero.
        srb_pkg::IDX_AUXFN: auxfn_d = wr_byte_q & srb_pkg::AUXFN_STORE;
        srb_pkg::IDX_BAUD_CTL: baud_ctl_d = wr_byte_q & srb_pkg::BAUD_CTL_STORE;
        srb_pkg::IDX_BAUD_LO: baud_lo_d = wr_byte_q;
        srb_pkg::IDX_BAUD_HI: baud_hi_d = wr_byte_q;
        srb_pkg::IDX_ACCUM: accum_d = wr_byte_q;
        srb_pkg::IDX_FLASH_LO: flash_lo_d = wr_byte_q;
        srb_pkg::IDX_FLASH_HI: flash_hi_d = wr_byte_q;
        srb_pkg::IDX_ARITH2: arith2_d = wr_byte_q;
        default: accum_d = accumulator_register_q;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      wr_idx_q <= 9'h000;
      wr_hi_q <= 1'b0;
      wr_byte_q <= 8'h00;
      wr_lane_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= srb_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= srb_pkg::RESP_OKAY;
      accumulator_register_q <= srb_pkg::RST_ACCUM;
      second_arith_register_q <= srb_pkg::RST_ARITH2;
      data_pointer_low_q <= srb_pkg::RST_DPTR_LO;
      data_pointer_high_q <= srb_pkg::RST_DPTR_HI;
      core_clock_divider_q <= srb_pkg::RST_CLKDIV;
      auxiliary_function_control_q <= srb_pkg::RST_AUXFN;
      baud_generator_control_q <= srb_pkg::RST_BAUD_CTL;
      baud_rate_low_byte_q <= srb_pkg::RST_BAUD_LO;
      baud_rate_high_byte_q <= srb_pkg::RST_BAUD_HI;
      flash_address_low_q <= srb_pkg::RST_FLASH_LO;
      flash_address_high_q <= srb_pkg::RST_FLASH_HI;
    end
    else
    begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      wr_idx_q <= wr_idx_d;
      wr_hi_q <= wr_hi_d;
      wr_byte_q <= wr_byte_d;
      wr_lane_q <= wr_lane_d;
      s_axi_awready <= awready_d;
      s_axi_wready <= wready_d;
      s_axi_bvalid <= bvalid_d;
      s_axi_bresp <= bresp_d;
      s_axi_arready <= arready_d;
      s_axi_rvalid <= rvalid_d;
      s_axi_rdata <= rdata_d;
      s_axi_rresp <= rresp_d;
      accumulator_register_q <= accum_d;
      second_arith_register_q <= arith2_d;
      data_pointer_low_q <= dptr_lo_d;
      data_pointer_high_q <= dptr_hi_d;
      core_clock_divider_q <= clkdiv_d;
      auxiliary_function_control_q <= auxfn_d;
      baud_generator_control_q <= baud_ctl_d;
      baud_rate_low_byte_q <= baud_lo_d;
      baud_rate_high_byte_q <= baud_hi_d;
      flash_address_low_q <= flash_lo_d;
      flash_address_high_q <= flash_hi_d;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_read_latency: assert property (ar_hs |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not one cycle after address");
  chk_unmapped_err: assert property (ar_hs && !rd_hit |=> s_axi_rresp == srb_pkg::RESP_SLVERR)
    else $error("unmapped read not answered with slverr");
  chk_aux_fixed_zero: assert property (ar_hs && !s_axi_araddr[11]
      && rd_idx == srb_pkg::IDX_AUXFN |=> s_axi_rdata[2:1] == 2'h0)
    else $error("fixed or reserved bit of aux register read nonzero");
  chk_baud_reserved: assert property (ar_hs && !s_axi_araddr[11]
      && rd_idx == srb_pkg::IDX_BAUD_CTL |=> s_axi_rdata[7:2] == 6'h00)
    else $error("reserved baud control bits read nonzero");
  chk_cmp_one_layout: assert property (cmp_one_wr
      |=> comparator_one_ctrl_q == $past(wr_byte_q[5:2]) && cmp_one_val[7:6] == 2'h0)
    else $error("comparator one control fields misplaced");
  chk_cmp_two_layout: assert property (cmp_two_wr
      |=> comparator_two_ctrl_q == $past(wr_byte_q[5:2]) && cmp_two_val[7:6] == 2'h0)
    else $error("comparator two control fields misplaced");
  chk_accum_bit_write: assert property (wr_en && bit_in(wr_idx_q, srb_pkg::BIT_GRP_ACCUM)
      |=> accumulator_register_q[$past(wr_idx_q[2:0])] == $past(wr_byte_q[0]))
    else $error("accumulator bit write lost");
  chk_arith2_bit_write: assert property (wr_en && bit_in(wr_idx_q, srb_pkg::BIT_GRP_ARITH2)
      |=> second_arith_register_q[$past(wr_idx_q[2:0])] == $past(wr_byte_q[0]))
    else $error("second arithmetic bit write lost");
  chk_accum_bit_read: assert property (ar_hs && !s_axi_araddr[11]
      && bit_in(rd_idx, srb_pkg::BIT_GRP_ACCUM)
      |=> s_axi_rdata == {31'h0, $past(accumulator_register_q[rd_idx[2:0]])})
    else $error("accumulator bit read wrong");
  chk_write_response: assert property (do_wr |=> s_axi_bvalid
      && s_axi_bresp == ($past(wr_hit) ? srb_pkg::RESP_OKAY : srb_pkg::RESP_SLVERR))
    else $error("write response missing or wrong");

  cov_byte_write: cover property (wr_en && !wr_idx_q[8]);
  cov_bit_write: cover property (wr_en && wr_idx_q[8]);
  cov_unmapped_read: cover property (ar_hs && !rd_hit);
  cov_back_to_back_read: cover property (ar_hs ##2 ar_hs);

endmodule : srb_top

/* tb/srb_top_tb.sv */
// Self-checking testbench for the special register bank slice over AXI4-Lite.
`timescale 1ns/1ps
module srb_top_tb;
  logic aclk;
  logic aresetn;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic cmp_one_pin, cmp_two_pin;
  logic [7:0] acc_q, arith_q, dpl_q, dph_q, div_q, aux_q, bctl_q, blo_q, bhi_q, flo_q, fhi_q;
  logic [3:0] c1_q, c2_q;
  int failures;
  int check_count;
  int cycles;

  srb_top dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .cmp_one_pin(cmp_one_pin), .cmp_two_pin(cmp_two_pin),
    .accumulator_register_q(acc_q), .second_arith_register_q(arith_q),
    .data_pointer_low_q(dpl_q), .data_pointer_high_q(dph_q),
    .core_clock_divider_q(div_q), .auxiliary_function_control_q(aux_q),
    .baud_generator_control_q(bctl_q), .baud_rate_low_byte_q(blo_q),
    .baud_rate_high_byte_q(bhi_q), .flash_address_low_q(flo_q),
    .flash_address_high_q(fhi_q),
    .comparator_one_ctrl_q(c1_q), .comparator_two_ctrl_q(c2_q)
  );

  // Plain read-write bytes, in the order that port_of returns them.
  localparam logic [8:0] RW_IDX [9] = '{srb_pkg::IDX_DPTR_LO, srb_pkg::IDX_DPTR_HI,
    srb_pkg::IDX_CLKDIV, srb_pkg::IDX_BAUD_LO, srb_pkg::IDX_BAUD_HI, srb_pkg::IDX_ACCUM,
    srb_pkg::IDX_FLASH_LO, srb_pkg::IDX_FLASH_HI, srb_pkg::IDX_ARITH2};

  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  function automatic logic [11:0] addr_of(input logic [8:0] idx);
    return {1'b0, idx, 2'b00};
  endfunction : addr_of

  function automatic logic [7:0] port_of(input int i);
    case (i)
      0: return dpl_q;
      1: return dph_q;
      2: return div_q;
      3: return blo_q;
      4: return bhi_q;
      5: return acc_q;
      6: return flo_q;
      7: return fhi_q;
      default: return arith_q;
    endcase
  endfunction : port_of

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out;
    if (failures == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  // Address and data are offered together and each is released once taken.
  task automatic wr(input logic [8:0] idx, input logic [7:0] d, input logic [3:0] strb,
                    output logic [1:0] resp);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= addr_of(idx);
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= strb;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready)
      begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready)
      begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [8:0] idx, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_araddr <= addr_of(idx);
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic wr_ok(input logic [8:0] idx, input logic [7:0] d);
    logic [1:0] r;
    wr(idx, d, 4'hf, r);
    check({30'h0, r}, {30'h0, srb_pkg::RESP_OKAY});
  endtask : wr_ok

  task automatic rd_exp(input logic [8:0] idx, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(idx, d, r);
    check(d, exp);
    check({30'h0, r}, {30'h0, er});
  endtask : rd_exp

  task automatic t_reset_values;
    foreach (RW_IDX[i])
    begin
      check({24'h0, port_of(i)}, 32'h0);
      rd_exp(RW_IDX[i], 32'h0, srb_pkg::RESP_OKAY);
    end
    rd_exp(srb_pkg::IDX_AUXFN, {24'h0, srb_pkg::RST_AUXFN}, srb_pkg::RESP_OKAY);
    rd_exp(srb_pkg::IDX_BAUD_CTL, {24'h0, srb_pkg::RST_BAUD_CTL}, srb_pkg::RESP_OKAY);
    rd_exp(srb_pkg::IDX_CMP_ONE, {24'h0, srb_pkg::RST_CMP}, srb_pkg::RESP_OKAY);
    rd_exp(srb_pkg::IDX_CMP_TWO, {24'h0, srb_pkg::RST_CMP}, srb_pkg::RESP_OKAY);
  endtask : t_reset_values

  // Two patterns per register catch both stuck bits and crossed byte decodes.
  task automatic t_plain_rw;
    foreach (RW_IDX[i])
      wr_ok(RW_IDX[i], 8'ha5 ^ 8'(i));
    foreach (RW_IDX[i])
    begin
      check({24'h0, port_of(i)}, {24'h0, 8'ha5 ^ 8'(i)});
      rd_exp(RW_IDX[i], {24'h0, 8'ha5 ^ 8'(i)}, srb_pkg::RESP_OKAY);
      wr_ok(RW_IDX[i], 8'h5a);
      rd_exp(RW_IDX[i], 32'h5a, srb_pkg::RESP_OKAY);
    end
  endtask : t_plain_rw

  task automatic t_fixed_bits;
    logic [1:0] r;
    wr_ok(srb_pkg::IDX_AUXFN, 8'hff);
    check({24'h0, aux_q}, 32'hf9);
    rd_exp(srb_pkg::IDX_AUXFN, 32'hf9, srb_pkg::RESP_OKAY);
    wr_ok(srb_pkg::IDX_BAUD_CTL, 8'hff);
    rd_exp(srb_pkg::IDX_BAUD_CTL, 32'h03, srb_pkg::RESP_OKAY);
    check({24'h0, bctl_q}, 32'h03);
    wr(srb_pkg::IDX_ACCUM, 8'h33, 4'he, r);
    check({30'h0, r}, {30'h0, srb_pkg::RESP_OKAY});
    check({24'h0, acc_q}, 32'h5a);
  endtask : t_fixed_bits

  task automatic t_unmapped;
    logic [1:0] r;
    rd_exp(9'h001, 32'h0, srb_pkg::RESP_SLVERR);
    rd_exp(9'h100, 32'h0, srb_pkg::RESP_SLVERR);
    wr(9'h001, 8'hff, 4'hf, r);
    check({30'h0, r}, {30'h0, srb_pkg::RESP_SLVERR});
    check({24'h0, dpl_q}, 32'h5a);
    @(posedge aclk);
    // Upper-half alias of accumulator bit 1, which holds a one at this point.
    s_axi_araddr <= 12'hf84;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    check(s_axi_rdata, 32'h0);
    check({30'h0, s_axi_rresp}, {30'h0, srb_pkg::RESP_SLVERR});
    s_axi_rready <= 1'b0;
  endtask : t_unmapped

  // Even bits of the accumulator and odd bits of the second register are set one by one.
  task automatic t_bits(input logic [8:0] base, input int first);
    logic [7:0] exp;
    wr_ok(base, 8'h00);
    exp = 8'h00;
    for (int b = first; b < 8; b += 2)
    begin
      wr_ok(srb_pkg::IDX_BIT_BASE + base + 9'(b), 8'h01);
      exp[b] = 1'b1;
      check({24'h0, (base == srb_pkg::IDX_ACCUM) ? acc_q : arith_q}, {24'h0, exp});
    end
    for (int b = 0; b < 8; b++)
      rd_exp(srb_pkg::IDX_BIT_BASE + base + 9'(b), {31'h0, exp[b]}, srb_pkg::RESP_OKAY);
    wr_ok(srb_pkg::IDX_BIT_BASE + base + 9'(first), 8'hfe);
    exp[first] = 1'b0;
    rd_exp(base, {24'h0, exp}, srb_pkg::RESP_OKAY);
  endtask : t_bits

  task automatic set_pin(input logic [8:0] idx, input logic v);
    @(posedge aclk);
    if (idx == srb_pkg::IDX_CMP_ONE)
      cmp_one_pin <= v;
    else
      cmp_two_pin <= v;
    repeat (12) @(posedge aclk);
  endtask : set_pin

  task automatic t_cmp(input logic [8:0] idx);
    wr_ok(idx, 8'hff);
    check({28'h0, (idx == srb_pkg::IDX_CMP_ONE) ? c1_q : c2_q}, 32'hf);
    rd_exp(idx, 32'h3c, srb_pkg::RESP_OKAY);
    wr_ok(idx, 8'h20);
    set_pin(idx, 1'b1);
    rd_exp(idx, 32'h23, srb_pkg::RESP_OKAY);
    wr_ok(idx, 8'h20);
    rd_exp(idx, 32'h22, srb_pkg::RESP_OKAY);
    set_pin(idx, 1'b0);
    rd_exp(idx, 32'h21, srb_pkg::RESP_OKAY);
    wr_ok(idx, 8'h00);
    set_pin(idx, 1'b1);
    rd_exp(idx, 32'h00, srb_pkg::RESP_OKAY);
    set_pin(idx, 1'b0);
  endtask : t_cmp

  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      close_out();
    end
  end

  initial
  begin
    failures = 0;
    check_count = 0;
    cycles = 0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awprot, s_axi_arprot} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {cmp_one_pin, cmp_two_pin} = 2'b00;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset_values();
    t_plain_rw();
    t_fixed_bits();
    t_unmapped();
    t_bits(srb_pkg::IDX_ACCUM, 0);
    t_bits(srb_pkg::IDX_ARITH2, 1);
    t_cmp(srb_pkg::IDX_CMP_ONE);
    t_cmp(srb_pkg::IDX_CMP_TWO);
    close_out();
  end
endmodule : srb_top_tb
